// >>> shared/ptmr_regs.svh
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH
`define PTMR_OFF_CTRL0    12'h000
`define PTMR_OFF_CTRL1    12'h004
`define PTMR_OFF_CNT_LO   12'h008
`define PTMR_OFF_CNT_HI   12'h00c
`define PTMR_OFF_CMPA_LO  12'h010
`define PTMR_OFF_CMPA_HI  12'h014
`define PTMR_OFF_CMPP_LO  12'h018
`define PTMR_OFF_CMPP_HI  12'h01c
`define PTMR_OFF_FLAGS    12'h020
`define PTMR_CTRL0_RESET  8'h00
`define PTMR_CTRL1_RESET  8'h00
`define PTMR_BIT_PAUSE    7
`define PTMR_BIT_ON       3
`define PTMR_BIT_OC       3
`define PTMR_BIT_POL      2
`define PTMR_BIT_CCLR     0
`define PTMR_CNT_MAX      10'h3ff
`define PTMR_DIV_HIGH     16
`define PTMR_DIV_SLOW     64
`define PTMR_DIV_SYS4     4
`endif

// >>> shared/ptmr_pkg.sv
package ptmr_pkg;
  typedef enum logic [2:0] {
    CK_SYS_DIV4, CK_SYS, CK_HIGH_DIV16, CK_HIGH_DIV64,
    CK_SUB_A, CK_SUB_B, CK_PIN_RISE, CK_PIN_FALL
  } ptmr_clksel_t;
  typedef enum logic [1:0] {
    MODE_COMPARE, MODE_UNDEF, MODE_PWM, MODE_TIMER
  } ptmr_mode_t;
  typedef logic [9:0] ptmr_count_t;
endpackage

// >>> shared/ptmr_tick_if.sv
interface ptmr_tick_if;
  import ptmr_pkg::*;
  ptmr_clksel_t sel;
  logic         tick;
  modport source (input sel, output tick);
  modport sink   (output sel, input tick);
endinterface

// >>> rtl/ptmr_tick_gen.sv
module ptmr_tick_gen (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic high_clk_en,
  input  wire logic sub_clk_en,
  input  wire logic pin_level,
  ptmr_tick_if.source tk
);
  import ptmr_pkg::*;
  logic [5:0] div_cnt;
  logic       pin_prev;
  logic [3:0] hi16_cnt;
  logic [5:0] hi64_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi16_cnt <= 4'h0;
      hi64_cnt <= 6'h00;
    end else if (high_clk_en) begin
      hi16_cnt <= hi16_cnt + 4'h1;
      hi64_cnt <= hi64_cnt + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end

  // Selected count clock as a one-cycle enable
  always_comb begin
    unique case (tk.sel)
      CK_SYS_DIV4:   tk.tick = (div_cnt[1:0] == 2'h3);
      CK_SYS:        tk.tick = 1'b1;
      CK_HIGH_DIV16: tk.tick = high_clk_en && (hi16_cnt == 4'hf);
      CK_HIGH_DIV64: tk.tick = high_clk_en && (hi64_cnt == 6'h3f);
      CK_SUB_A,
      CK_SUB_B:      tk.tick = sub_clk_en;
      CK_PIN_RISE:   tk.tick = pin_level && !pin_prev;
      CK_PIN_FALL:   tk.tick = !pin_level && pin_prev;
    endcase
  end
endmodule

// >>> rtl/ptmr_top.sv
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`include "ptmr_regs.svh"
module ptmr_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  high_clk_en,
  input  wire logic                  sub_clk_en,
  input  wire logic                  external_count_input,
  output logic                       timer_output_pin,
  output logic                       timer_output_oe,
  output logic                       timer_event
);
  import ptmr_pkg::*;

  logic        pin_meta;
  logic        pin_sync;
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  ptmr_count_t count;
  ptmr_count_t compare_a_value;
  ptmr_count_t compare_p_value;
  logic        compare_a_flag;
  logic        compare_p_flag;
  logic        on_prev;
  logic        out_level;
  logic        pulse_done;
  logic        tick;
  logic        next_on;
  logic        on_rise;
  logic        run;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clear_cnt;
  logic        set_a;
  logic        set_p;
  logic        next_pin;
  logic        wr_ctrl0;
  logic        wr_flags;
  logic [7:0]  wbyte;
  ptmr_mode_t  mode;
  logic [1:0]  pin_fn;

  ptmr_tick_if tk_if ();

  ptmr_tick_gen u_tick (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .high_clk_en (high_clk_en),
    .sub_clk_en  (sub_clk_en),
    .pin_level   (pin_sync),
    .tk          (tk_if.source)
  );

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= external_count_input;
      pin_sync <= pin_meta;
    end
  end

  assign mode         = ptmr_mode_t'(ctrl1[7:6]);
  assign pin_fn       = ctrl1[5:4];
  assign tk_if.sel    = ptmr_clksel_t'(ctrl0[6:4]);
  assign tick         = tk_if.tick;
  assign wbyte        = hwdata[7:0];
  assign wr_ctrl0     = wr_pend && addr_is(wr_addr, `PTMR_OFF_CTRL0);
  assign wr_flags     = wr_pend && addr_is(wr_addr, `PTMR_OFF_FLAGS);
  assign next_on      = wr_ctrl0 ? wbyte[`PTMR_BIT_ON] : (ctrl0[`PTMR_BIT_ON] && !pulse_done);
  assign on_rise      = ctrl0[`PTMR_BIT_ON] && !on_prev;
  assign run          = ctrl0[`PTMR_BIT_ON] && !ctrl0[`PTMR_BIT_PAUSE] && !on_rise && tick;
  assign match_a      = run && (count == compare_a_value) && (compare_a_value != 10'h000);
  assign match_p      = run && (count == compare_p_value) && (compare_p_value != 10'h000);
  assign overflow     = run && (count == `PTMR_CNT_MAX);

  // Clear source per mode
  always_comb begin
    set_a     = match_a;
    set_p     = match_p;
    clear_cnt = 1'b0;
    if (mode == MODE_PWM) begin
      // Single pulse leaves comparator P out of the counter clear
      clear_cnt = (pin_fn != 2'h3) && (match_p || (overflow && compare_p_value == 10'h000));
    end else if (ctrl1[`PTMR_BIT_CCLR]) begin
      clear_cnt = match_a || overflow;
      set_p     = 1'b0;
    end else begin
      clear_cnt = match_p || (overflow && compare_p_value == 10'h000);
    end
  end

  // Bus data phase tracking; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[11:0])
        `PTMR_OFF_CTRL0:   hrdata <= {24'h000000, ctrl0[7:3], 3'h0};
        `PTMR_OFF_CTRL1:   hrdata <= {24'h000000, ctrl1};
        `PTMR_OFF_CNT_LO:  hrdata <= {24'h000000, count[7:0]};
        `PTMR_OFF_CNT_HI:  hrdata <= {30'h0, count[9:8]};
        `PTMR_OFF_CMPA_LO: hrdata <= {24'h000000, compare_a_value[7:0]};
        `PTMR_OFF_CMPA_HI: hrdata <= {30'h0, compare_a_value[9:8]};
        `PTMR_OFF_CMPP_LO: hrdata <= {24'h000000, compare_p_value[7:0]};
        `PTMR_OFF_CMPP_HI: hrdata <= {30'h0, compare_p_value[9:8]};
        `PTMR_OFF_FLAGS:   hrdata <= {30'h0, compare_p_flag, compare_a_flag};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0   <= `PTMR_CTRL0_RESET;
      on_prev <= 1'b0;
    end else begin
      ctrl0   <= {(wr_ctrl0 ? wbyte[7:4] : ctrl0[7:4]), next_on, 3'h0};
      on_prev <= ctrl0[`PTMR_BIT_ON];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1 <= `PTMR_CTRL1_RESET;
    end else if (wr_pend && addr_is(wr_addr, `PTMR_OFF_CTRL1)) begin
      ctrl1 <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a_value <= 10'h000;
      compare_p_value <= 10'h000;
    end else if (wr_pend) begin
      if (addr_is(wr_addr, `PTMR_OFF_CMPA_LO)) compare_a_value[7:0] <= wbyte;
      if (addr_is(wr_addr, `PTMR_OFF_CMPA_HI)) compare_a_value[9:8] <= wbyte[1:0];
      if (addr_is(wr_addr, `PTMR_OFF_CMPP_LO)) compare_p_value[7:0] <= wbyte;
      if (addr_is(wr_addr, `PTMR_OFF_CMPP_HI)) compare_p_value[9:8] <= wbyte[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 10'h000;
    end else if (on_rise) begin
      count <= 10'h000;
    end else if (clear_cnt) begin
      count <= 10'h000;
    end else if (run) begin
      count <= count + 10'h001;
    end
  end

  // Set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      compare_a_flag <= set_a || (compare_a_flag && !(wr_flags && wbyte[0]));
      compare_p_flag <= set_p || (compare_p_flag && !(wr_flags && wbyte[1]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_event <= 1'b0;
    end else begin
      timer_event <= set_a || set_p;
    end
  end

  // Single pulse ends on A match by dropping the on bit
  assign pulse_done = (mode == MODE_PWM) && (pin_fn == 2'h3) && match_a;

  // Unpolarised output level
  always_comb begin
    next_pin = out_level;
    if (mode == MODE_COMPARE) begin
      if (on_rise) begin
        next_pin = ctrl1[`PTMR_BIT_OC];
      end else if (match_a) begin
        unique case (pin_fn)
          2'h0: next_pin = out_level;
          2'h1: next_pin = 1'b0;
          2'h2: next_pin = 1'b1;
          2'h3: next_pin = !out_level;
        endcase
      end
    end else if (mode == MODE_PWM) begin
      unique case (pin_fn)
        2'h0: next_pin = !ctrl1[`PTMR_BIT_OC];
        2'h1: next_pin = ctrl1[`PTMR_BIT_OC];
        2'h2: next_pin = ((count < compare_a_value) && ctrl0[`PTMR_BIT_ON]) ? ctrl1[`PTMR_BIT_OC]
                                                                           : !ctrl1[`PTMR_BIT_OC];
        2'h3: next_pin = on_rise ? ctrl1[`PTMR_BIT_OC]
                       : (ctrl0[`PTMR_BIT_ON] && !pulse_done) ? out_level : !ctrl1[`PTMR_BIT_OC];
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_level <= 1'b0;
    end else begin
      out_level <= next_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
      timer_output_oe  <= 1'b0;
    end else begin
      timer_output_pin <= next_pin ^ ctrl1[`PTMR_BIT_POL];
      timer_output_oe  <= (mode == MODE_COMPARE) || (mode == MODE_PWM);
    end
  end

  chk_on_rise_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    on_rise |=> count == 10'h000)
    else $error("counter not cleared on enable");
  chk_pause_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl0[7] && !on_rise && $past(ctrl0[7])) |=> $stable(count) || $past(on_rise))
    else $error("counter moved while paused");
  chk_off_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl0[3] && !$rose(ctrl0[3])) ##1 !ctrl0[3] |-> $stable(count))
    else $error("counter moved while off");
  chk_cclr_a_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (match_a && ctrl1[0] && mode != MODE_PWM) |=> count == 10'h000)
    else $error("A match did not clear");
  chk_no_p_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl1[0] && mode != MODE_PWM && !compare_p_flag && !wr_flags) |=> !compare_p_flag)
    else $error("P flag set with A clear");
  chk_a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    match_a |=> compare_a_flag)
    else $error("A flag missing");
  chk_a_zero_noflag: assert property (@(posedge hclk) disable iff (!hresetn)
    (compare_a_value == 10'h000) |-> !match_a)
    else $error("A match with zero compare");
  chk_overflow_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (overflow && !on_rise) |=> count == 10'h000)
    else $error("overflow did not wrap");
  chk_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> timer_output_pin == (out_level ^ $past(ctrl1[2])))
    else $error("output polarity wrong");
  chk_timer_undriven: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_TIMER |=> !timer_output_oe)
    else $error("pin driven in timer mode");
  chk_count_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    (!on_rise && !run) |=> $stable(count))
    else $error("counter moved without a tick");
  chk_p_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (match_p && !ctrl1[0] && mode != MODE_PWM) |=> count == 10'h000)
    else $error("P match did not clear");
  chk_event_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (set_a || set_p) |=> timer_event)
    else $error("event missing after match");
  chk_on_rise_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (on_rise && mode == MODE_COMPARE) |=> out_level == $past(ctrl1[3]))
    else $error("initial level not restored");
  chk_cmp_pin_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_COMPARE && !on_rise && !match_a) |=> out_level == $past(out_level))
    else $error("pin moved without A match");
  chk_pwm_forced: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == MODE_PWM && pin_fn == 2'h0) |=> out_level == !$past(ctrl1[3]))
    else $error("inactive level not forced");
  chk_pulse_stops: assert property (@(posedge hclk) disable iff (!hresetn)
    (pulse_done && !wr_ctrl0) |=> !ctrl0[3])
    else $error("pulse did not end");
  chk_pwm_driven: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_PWM |=> timer_output_oe)
    else $error("pin idle in PWM mode");
  cov_compare_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_COMPARE && pin_fn == 2'h3 && match_a);
  cov_pwm_period: cover property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_PWM && match_p);
  cov_single_pulse: cover property (@(posedge hclk) disable iff (!hresetn) pulse_done);
  cov_overflow: cover property (@(posedge hclk) disable iff (!hresetn) overflow);
endmodule

// >>> verification/ptmr_pin_model.sv
module ptmr_pin_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic go,
  output logic      external_count_input,
  output logic      high_clk_en,
  output logic      sub_clk_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] left;
  logic [2:0] ph;
  // Nine pin pulses, 4 clocks high in every 8, after each go; pin rests low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= 7'h00;
      ph   <= 3'h0;
    end else begin
      ph <= ph + 3'h1;
      if (go) begin
        left <= 7'h48;
      end else if (left != 7'h00) begin
        left <= left - 7'h01;
      end
    end
  end
  assign external_count_input = (left != 7'h00) && left[2];
  assign high_clk_en          = ph[0];
  assign sub_clk_en           = (ph[1:0] == 2'h3);
endmodule

// >>> verification/periodic_timer_10bit_bench.sv
`include "ptmr_regs.svh"
module periodic_timer_10bit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] C0 = `PTMR_OFF_CTRL0;
  localparam logic [11:0] C1 = `PTMR_OFF_CTRL1;
  localparam logic [11:0] DL = `PTMR_OFF_CNT_LO;
  localparam logic [11:0] DH = `PTMR_OFF_CNT_HI;
  localparam logic [11:0] AL = `PTMR_OFF_CMPA_LO;
  localparam logic [11:0] AH = `PTMR_OFF_CMPA_HI;
  localparam logic [11:0] PL = `PTMR_OFF_CMPP_LO;
  localparam logic [11:0] PH = `PTMR_OFF_CMPP_HI;
  localparam logic [11:0] FL = `PTMR_OFF_FLAGS;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} ptmr_rrow_t;
  typedef struct {logic [7:0] c; logic i; logic f; logic o;} ptmr_prow_t;
  typedef struct {logic [2:0] s; logic [9:0] lo; logic [9:0] hi;} ptmr_srow_t;
  ptmr_rrow_t rr[9] = '{'{C0, 8'h77, 8'h70}, '{C1, 8'hf9, 8'hf9}, '{DL, 8'hff, 8'h00}, '{DH, 8'hff, 8'h00},
    '{AL, 8'ha5, 8'ha5}, '{AH, 8'hff, 8'h03}, '{PL, 8'h5a, 8'h5a}, '{PH, 8'hfe, 8'h02}, '{12'h040, 8'hff, 8'h00}};
  // Control one, level after on, level after first A match, enable
  ptmr_prow_t pr[12] = '{'{8'h39, 1'b1, 1'b0, 1'b1}, '{8'h3d, 1'b0, 1'b1, 1'b1}, '{8'h19, 1'b1, 1'b0, 1'b1},
    '{8'h21, 1'b0, 1'b1, 1'b1}, '{8'h29, 1'b1, 1'b1, 1'b1}, '{8'h09, 1'b1, 1'b1, 1'b1},
    '{8'h98, 1'b1, 1'b1, 1'b1}, '{8'h88, 1'b0, 1'b0, 1'b1}, '{8'ha9, 1'b1, 1'b0, 1'b1},
    '{8'hb8, 1'b1, 1'b0, 1'b1}, '{8'hc8, 1'b1, 1'b1, 1'b0}, '{8'h48, 1'b1, 1'b1, 1'b0}};
  ptmr_srow_t sr[8] = '{'{3'h0, 10'd156, 10'd164}, '{3'h1, 10'd636, 10'd646}, '{3'h2, 10'd18, 10'd22},
    '{3'h3, 10'd4, 10'd6}, '{3'h4, 10'd156, 10'd164}, '{3'h5, 10'd156, 10'd164}, '{3'h6, 10'd9, 10'd9},
    '{3'h7, 10'd9, 10'd9}};
  logic [11:0] rz[5] = '{C0, C1, AH, DL, DH};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go, hce, sce, ext, pin, oe, ev, pin_seen;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_total, n_compared;

  assign hready = hreadyout;
  // Pin is pulled up while the timer does not drive it
  assign pin_seen = oe ? pin : 1'b1;

  ptmr_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .high_clk_en(hce), .sub_clk_en(sce), .external_count_input(ext), .timer_output_pin(pin),
    .timer_output_oe(oe), .timer_event(ev));
  ptmr_pin_model pm (.hclk(hclk), .hresetn(hresetn), .go(go), .external_count_input(ext),
    .high_clk_en(hce), .sub_clk_en(sce));

  always #2.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wt();
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wt();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    wt();
    d = hrdata;
  endtask

  task automatic cr(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #150us;
    err_total++;
    close_out();
  end

  initial begin
    logic [31:0] v;
    logic [31:0] h;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rr[i]) begin
      wr(rr[i].a, rr[i].d);
      cr(rr[i].a, {24'h0, rr[i].e});
      chk(hresp, 1'b0);
    end
    wr(C1, 8'h00);
    wr(AH, 8'h00);
    wr(PL, 8'h00);
    wr(PH, 8'h00);
    wr(AL, 8'h05);
    foreach (pr[i]) begin
      wr(C0, 8'h00);
      wr(C1, pr[i].c);
      wr(C0, 8'h18);
      repeat (3) @(posedge hclk);
      #1;
      chk(pin_seen, pr[i].i);
      chk(oe, pr[i].o);
      repeat (8) @(posedge hclk);
      #1;
      chk(pin_seen, pr[i].f);
    end
    wr(C0, 8'h00);
    wr(AL, 8'h00);
    wr(C1, 8'hc0);
    wr(C0, 8'h18);
    repeat (20) @(posedge hclk);
    wr(C0, 8'h98);
    rd(DL, v);
    chk(v >= 32'd20 && v <= 32'd24, 1'b1);
    cr(DL, v);
    wr(C0, 8'h18);
    rd(DL, h);
    chk(h > v && h <= v + 32'd3, 1'b1);
    wr(C0, 8'h10);
    rd(DL, v);
    repeat (10) @(posedge hclk);
    cr(DL, v);
    wr(C0, 8'h98);
    cr(DL, 32'h0);
    foreach (sr[i]) begin
      wr(C0, 8'h00);
      wr(C0, {1'b0, sr[i].s, 4'h8});
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      repeat (640) @(posedge hclk);
      wr(C0, {1'b1, sr[i].s, 4'h8});
      rd(DL, v);
      rd(DH, h);
      v = {22'h0, h[1:0], v[7:0]};
      chk(v >= {22'h0, sr[i].lo} && v <= {22'h0, sr[i].hi}, 1'b1);
    end
    wr(C0, 8'h00);
    wr(FL, 8'h03);
    wr(AL, 8'h03);
    wr(PL, 8'h07);
    wr(C0, 8'h18);
    for (int n = 0; n < 50 && ev !== 1'b1; n++) @(negedge hclk);
    chk(ev, 1'b1);
    repeat (20) @(posedge hclk);
    cr(FL, 32'h3);
    wr(C0, 8'h00);
    wr(PL, 8'h02);
    wr(C1, 8'hc1);
    wr(FL, 8'h03);
    wr(C0, 8'h18);
    repeat (20) @(posedge hclk);
    cr(FL, 32'h1);
    wr(C0, 8'h00);
    wr(AL, 8'h00);
    wr(PL, 8'h00);
    wr(C1, 8'h00);
    wr(FL, 8'h03);
    wr(C0, 8'h18);
    repeat (1100) @(posedge hclk);
    rd(FL, v);
    chk(v[0], 1'b0);
    rd(DL, v);
    chk(v >= 32'd70 && v <= 32'd90, 1'b1);
    cr(DH, 32'h0);
    wr(C1, 8'hc1);
    wr(AH, 8'h03);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rz[i]) cr(rz[i], 32'h0);
    close_out();
  end
endmodule
